/* design/odt_dev.sv */
// device end: synchronous and dynamic on-die termination control
// Operation
// [R1] termination follows pin after write latency minus two
// [R2] controller holds pin high four cycles minimum
// [R3] write with pin high extends hold 4/6
// [R4] controller meets later of both hold intervals
// [R5] controller drops pin around reads
// [R6] termination returns when device stops driving bus
// [R7] dynamic mode on if either write bit set
// [R8] nominal three-bit, write two-bit strength fields
// [R9] no write: nominal strength, pin timing only
// [R10] write switches to write strength after latency
// [R11] back to nominal after off latency plus 4/6
// [R12] controller clears write field before dll off; not done here, odt_dev drops termination while dll_locked_i is low
// [R13] sync only with dll locked; additive latency adds
// [R14] pin ignored in self-refresh or all fields zero
// [R15] dynamic off: writes keep nominal strength
`timescale 1ns/1ps
`include "odt_defs.svh"
module odt_dev
    import odt_pkg::*;
#(
    parameter int LAT_W = `ODT_LAT_W
)
(
    input wire logic clock_i,
    input wire logic rst_b_i,
    odt_if.dev link,
    input wire logic [LAT_W-1:0] cas_write_latency_i,
    input wire logic [LAT_W-1:0] additive_latency_i,
    input wire odt_nom_t rtt_nom_i,
    input wire odt_wr_t rtt_wr_i,
    input wire logic dll_locked_i,
    input wire logic self_refresh_i,
    input wire logic rd_drive_i,
    output logic term_en_o,
    output odt_str_t term_str_o,
    output logic [`ODT_RTT_NOM_W-1:0] term_value_o
);
    typedef struct packed {
        logic [`ODT_PIPE_W-1:0] pipe;
        logic [`ODT_CNT_W-1:0] cnw_cnt;
        logic [`ODT_CNT_W-1:0] cwn_cnt;
        logic wr_sel;
        logic term_en;
        odt_str_t str;
        logic [`ODT_RTT_NOM_W-1:0] value;
    } odt_dev_state_t;

    odt_dev_state_t cur_ff;
    odt_dev_state_t nxt_st;
    logic [LAT_W-1:0] write_latency_total;
    logic [LAT_W-1:0] term_on_latency;
    logic [LAT_W-1:0] term_off_latency;
    logic [LAT_W-1:0] nominal_to_write_switch_latency;
    logic [LAT_W-1:0] write_to_nominal_latency_chop;
    logic [LAT_W-1:0] write_to_nominal_latency_full;
    logic dyn_en;
    logic odt_enabled;
    logic pin_q;
    logic delayed_pin;
    logic [`ODT_PIPE_W-1:0] tap_hit;

    assign write_latency_total = LAT_W'(cas_write_latency_i + additive_latency_i); // R13
    assign term_on_latency = LAT_W'(write_latency_total - `ODT_LAT_OFFSET); // R1
    assign term_off_latency = term_on_latency;
    assign nominal_to_write_switch_latency = term_on_latency; // R10
    assign write_to_nominal_latency_chop = LAT_W'(term_off_latency + `ODT_CWN_CHOP); // R11
    assign write_to_nominal_latency_full = LAT_W'(term_off_latency + `ODT_CWN_FULL); // R11
    assign dyn_en = |rtt_wr_i; // R7
    assign odt_enabled = (|rtt_nom_i || dyn_en) && !self_refresh_i && dll_locked_i; // R14 R13
    assign pin_q = link.term_req && odt_enabled;
    // one tap per pipeline stage; only the stage matching the latency can hit
    generate
        for (genvar gi = 0; gi < `ODT_PIPE_W; gi++)
        begin : g_tap
            assign tap_hit[gi] = cur_ff.pipe[gi] && (int'(term_on_latency) == gi + 1); // R1
        end
    endgenerate
    // latency zero means the pin acts on the same edge it is registered
    assign delayed_pin = (term_on_latency == '0) ? pin_q : |tap_hit; // R1
    assign link.rd_drive = rd_drive_i;

    always_comb
    begin
        nxt_st = cur_ff;
        nxt_st.pipe = {cur_ff.pipe[`ODT_PIPE_W-2:0], pin_q};
        if (cur_ff.cnw_cnt != '0)
        begin
            nxt_st.cnw_cnt = cur_ff.cnw_cnt - `ODT_CNT_ONE;
            if (cur_ff.cnw_cnt == `ODT_CNT_ONE)
            begin
                nxt_st.wr_sel = 1'b1; // R10
            end
        end
        if (cur_ff.cwn_cnt != '0)
        begin
            nxt_st.cwn_cnt = cur_ff.cwn_cnt - `ODT_CNT_ONE;
            if (cur_ff.cwn_cnt == `ODT_CNT_ONE)
            begin
                nxt_st.wr_sel = 1'b0; // R11
            end
        end
        // a new write restarts both counters; a later write overrides an earlier return
        if (link.wr_cmd && dyn_en && odt_enabled) // R15
        begin
            nxt_st.cnw_cnt = `ODT_CNT_W'(nominal_to_write_switch_latency);
            if (link.wr_full)
            begin
                nxt_st.cwn_cnt = `ODT_CNT_W'(write_to_nominal_latency_full); // R11
            end
            else
            begin
                nxt_st.cwn_cnt = `ODT_CNT_W'(write_to_nominal_latency_chop); // R11
            end
            if (nominal_to_write_switch_latency == '0)
            begin
                nxt_st.wr_sel = 1'b1;
            end
        end
        if (!dyn_en)
        begin
            nxt_st.wr_sel = 1'b0; // R15
        end
        // termination is held off while the device drives the bus
        nxt_st.term_en = delayed_pin && !rd_drive_i; // R6 R9
        if (!nxt_st.term_en)
        begin
            nxt_st.str = ODT_STR_OFF;
            nxt_st.value = '0;
        end
        else if (nxt_st.wr_sel)
        begin
            nxt_st.str = ODT_STR_WR; // R10
            nxt_st.value = `ODT_RTT_NOM_W'(rtt_wr_i); // R8
        end
        else
        begin
            nxt_st.str = ODT_STR_NOM; // R9
            nxt_st.value = rtt_nom_i; // R8
        end
    end

    always_ff @(posedge clock_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            cur_ff <= '0;
        end
        else
        begin
            cur_ff <= nxt_st;
        end
    end

    assign term_en_o = cur_ff.term_en;
    assign term_str_o = cur_ff.str;
    assign term_value_o = cur_ff.value;
endmodule

/* design/odt_defs.svh */
// timing constants for the on-die termination control block
`ifndef ODT_DEFS_SVH
`define ODT_DEFS_SVH
`define ODT_LAT_OFFSET 5'h2
`define ODT_HIGH_SHORT 4'h4
`define ODT_HIGH_LONG 4'h6
`define ODT_CWN_CHOP 5'h4
`define ODT_CWN_FULL 5'h6
`define ODT_RTT_NOM_W 3
`define ODT_RTT_WR_W 2
`define ODT_LAT_W 5
`define ODT_CNT_W 5
`define ODT_CNT_ONE 5'h1
`define ODT_HOLD_ONE 4'h1
`define ODT_PIPE_W 32
`endif

/* design/odt_pkg.sv */
// types shared by both ends of the on-die termination link
`include "odt_defs.svh"
package odt_pkg;
    typedef logic [`ODT_RTT_NOM_W-1:0] odt_nom_t;
    typedef logic [`ODT_RTT_WR_W-1:0] odt_wr_t;
    typedef logic [`ODT_LAT_W-1:0] odt_lat_t;
    typedef enum logic [1:0] {ODT_STR_OFF, ODT_STR_NOM, ODT_STR_WR} odt_str_t;
endpackage

/* design/odt_if.sv */
// link between memory controller and device termination control
`timescale 1ns/1ps
interface odt_if;
    logic term_req;
    logic wr_cmd;
    logic wr_full;
    logic rd_drive;
    modport ctrl (output term_req, output wr_cmd, output wr_full, input rd_drive);
    modport dev (input term_req, input wr_cmd, input wr_full, output rd_drive);
endinterface

/* design/odt_ctrl.sv */
// controller end: drives termination pin meeting minimum high times
`timescale 1ns/1ps
`include "odt_defs.svh"
module odt_ctrl
    import odt_pkg::*;
(
    input wire logic clock_i,
    input wire logic rst_b_i,
    odt_if.ctrl link,
    input wire logic term_want_i,
    input wire logic wr_req_i,
    input wire logic wr_full_i,
    input wire logic rd_block_i,
    output logic term_pin_o,
    output logic busy_o
);
    typedef struct packed {
        logic pin;
        logic [3:0] hold;
        logic wr;
        logic full;
    } odt_ctrl_state_t;

    odt_ctrl_state_t cur_ff;
    odt_ctrl_state_t nxt_st;

    always_comb
    begin
        nxt_st = cur_ff;
        nxt_st.wr = 1'b0;
        nxt_st.full = wr_full_i;
        if (cur_ff.hold > `ODT_HOLD_ONE)
        begin
            nxt_st.hold = cur_ff.hold - `ODT_HOLD_ONE;
        end
        else
        begin
            nxt_st.hold = '0;
        end
        if (!cur_ff.pin && term_want_i && !rd_block_i)
        begin
            nxt_st.pin = 1'b1;
            nxt_st.hold = `ODT_HIGH_SHORT; // R2
        end
        else if (cur_ff.pin && cur_ff.hold <= `ODT_HOLD_ONE && (!term_want_i || rd_block_i))
        begin
            nxt_st.pin = 1'b0; // R4 R5
        end
        if (wr_req_i)
        begin
            nxt_st.wr = 1'b1;
            if (nxt_st.pin)
            begin
                nxt_st.hold = wr_full_i ? `ODT_HIGH_LONG : `ODT_HIGH_SHORT; // R3 R4
                if (nxt_st.hold < cur_ff.hold)
                begin
                    nxt_st.hold = cur_ff.hold;
                end
            end
        end
    end

    always_ff @(posedge clock_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            cur_ff <= '0;
        end
        else
        begin
            cur_ff <= nxt_st;
        end
    end

    assign link.term_req = cur_ff.pin;
    assign link.wr_cmd = cur_ff.wr;
    assign link.wr_full = cur_ff.full;
    assign term_pin_o = cur_ff.pin;
    assign busy_o = cur_ff.hold != '0;
endmodule

/* verif/odt_link_sva.sv */
// concurrent checks on the termination link between the two ends
`timescale 1ns/1ps
module odt_link_sva (
    input wire logic clock_i,
    input wire logic rst_b_i,
    input wire logic term_req,
    input wire logic wr_cmd,
    input wire logic wr_full,
    input wire logic rd_drive
);
    logic wr_hi;
    logic wr_hi_full;
    assign wr_hi = wr_cmd && term_req;
    assign wr_hi_full = wr_cmd && term_req && wr_full;
    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (!rst_b_i);
    a_hold_after_rise: assert property ($rose(term_req) |-> term_req[*4])
        else $error("pin low before minimum high time");
    a_hold_after_chop: assert property (wr_cmd && term_req && !wr_full |-> term_req[*4])
        else $error("pin low too soon after short write");
    a_hold_after_full: assert property (wr_cmd && term_req && wr_full |-> term_req[*6])
        else $error("pin low too soon after full write");
    a_write_one_cycle: assert property (wr_cmd |=> !wr_cmd)
        else $error("write pulse longer than one cycle");
    a_drop_after_rise: assert property ($fell(term_req) |-> $past(term_req, 4))
        else $error("pin dropped less than four cycles after rising");
    a_drop_after_write: assert property ($fell(term_req) |-> !$past(wr_hi, 1) && !$past(wr_hi, 2) && !$past(wr_hi, 3))
        else $error("pin dropped within four cycles of a write");
    a_drop_after_long: assert property ($fell(term_req) |-> !$past(wr_hi_full, 4) && !$past(wr_hi_full, 5))
        else $error("pin dropped within six cycles of a full write");
    c_full: cover property (wr_cmd && term_req && wr_full);
    c_chop: cover property (wr_cmd && term_req && !wr_full);
    c_drop: cover property ($fell(term_req));
    c_read: cover property (rd_drive);
endmodule

/* verif/tb.sv */
// bench: controller and device ends joined, device output checked against a model
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin err_count++; \
    $display("CHECK FAILED %s exp %0h got %0h", nm, ex, got); end end
module tb;
    import odt_pkg::*;
    localparam logic [20:0] NOM_T = {3'h4, 3'h2, 3'h5, 3'h0, 3'h0, 3'h3, 3'h1};
    localparam logic [13:0] WR_T = {2'h3, 2'h0, 2'h2, 2'h0, 2'h1, 2'h0, 2'h2};
    logic clock_i = 0;
    logic rst_b_i = 0;
    logic want = 0, wreq = 0, wful = 0, rblk = 0, dll = 1, sr = 0, rdd = 0, cmp = 0;
    logic [4:0] cas_write_latency = 5'h05, al = 5'h00;
    odt_nom_t nom = 3'h1;
    odt_wr_t wrv = 2'h2;
    logic en, pin, busy;
    odt_str_t str, ex;
    logic [2:0] val;
    logic [31:0] pin_h = 0, wr_h = 0, ful_h = 0, rd_h = 0;
    integer seed = 55598, err_count = 0, n_tests = 0, ph, gap, lat;
    always #5 clock_i = ~clock_i;
    odt_if link ();
    odt_ctrl odt_ctrl_inst (.clock_i(clock_i), .rst_b_i(rst_b_i), .link(link), .term_want_i(want),
        .wr_req_i(wreq), .wr_full_i(wful), .rd_block_i(rblk), .term_pin_o(pin), .busy_o(busy));
    odt_dev odt_dev_inst (.clock_i(clock_i), .rst_b_i(rst_b_i), .link(link), .cas_write_latency_i(cas_write_latency),
        .additive_latency_i(al), .rtt_nom_i(nom), .rtt_wr_i(wrv), .dll_locked_i(dll), .self_refresh_i(sr),
        .rd_drive_i(rdd), .term_en_o(en), .term_str_o(str), .term_value_o(val));
    odt_link_sva odt_link_sva_inst (.clock_i(clock_i), .rst_b_i(rst_b_i), .term_req(link.term_req),
        .wr_cmd(link.wr_cmd), .wr_full(link.wr_full), .rd_drive(link.rd_drive));
    // bit k of each history holds what the device registered k edges ago
    always @(posedge clock_i)
    begin
        pin_h <= {pin_h[30:0], link.term_req};
        wr_h <= {wr_h[30:0], link.wr_cmd};
        ful_h <= {ful_h[30:0], link.wr_full};
        rd_h <= {rd_h[30:0], rdd};
    end
    function automatic odt_str_t exp_str(input int l);
        odt_str_t s;
        int k;
        s = ODT_STR_OFF;
        if (pin_h[l] && dll && !sr && !rd_h[0] && (nom != 3'h0 || wrv != 2'h0))
        begin
            s = ODT_STR_NOM;
            for (k = l; k < l + 6; k++)
                if (wr_h[k] && wrv != 2'h0 && k < l + (ful_h[k] ? 6 : 4))
                    s = ODT_STR_WR;
        end
        return s;
    endfunction
    always @(negedge clock_i)
        if (cmp)
        begin
            ex = exp_str(lat);
            `CHK("term_str_o", ex, str)
            `CHK("term_en_o", ex != ODT_STR_OFF, en)
            `CHK("term_value_o", ex == ODT_STR_WR ? {1'b0, wrv} : ex == ODT_STR_NOM ? nom : 3'h0, val)
        end
    task automatic give_verdict();
        $display("checks %0d, mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // phases take about 2400 cycles; four times that is a hang
    initial
    begin
        #100000;
        err_count++;
        give_verdict();
    end
    // phases: dynamic, writes without dynamic, nominal zero, all zero, self-refresh, dll unlocked, reads
    initial
    begin
        repeat (5) @(posedge clock_i);
        rst_b_i <= 1'b1;
        for (ph = 0; ph < 7; ph++)
        begin
            @(posedge clock_i);
            want <= 0;
            wreq <= 0;
            rdd <= 0;
            cas_write_latency <= 5'h05 + ph % 3;
            al <= ph % 4;
            nom <= NOM_T[ph*3+:3];
            wrv <= WR_T[ph*2+:2];
            sr <= ph == 4;
            dll <= ph != 5;
            // drain the pipeline so old traffic cannot meet new settings
            repeat (40) @(posedge clock_i);
            lat = 3 + ph % 3 + ph % 4;
            cmp = 1;
            gap = 0;
            repeat (300) @(posedge clock_i)
            begin
                want <= ($random(seed) & 3) != 0;
                rblk <= ($random(seed) & 15) == 0;
                rdd <= ph == 6 && ($random(seed) & 7) == 0;
                wreq <= 0;
                if (gap > 0)
                    gap--;
                else if ($random(seed) & 1)
                begin
                    wreq <= 1;
                    wful <= $random(seed) & 1;
                    gap = lat + 8;
                end
            end
            cmp = 0;
            $display("test %0d done, checks %0d, mismatches %0d", ph, n_tests, err_count);
        end
        give_verdict();
    end
endmodule
